// *** design/msc_pkg.sv ***
/*
  Constants for the interrupt-message capability and configuration access block.
  Assumes dword-aligned configuration accesses with a 12-bit byte address.
*/
// What this block does
// - Interrupt-message capability next pointer always reads zero, last in list.
// - Interrupt messages go out only while the enable bit is one; resets zero.
// - Requested message count field is read-only zero, one message.
// - Exactly one message is used whatever the granted-count field holds.
// - Wide address capable bit reads as a fixed one.
// - Lower message address is writable above bit 1; bits 1:0 read zero.
// - Every interrupt message is forwarded out through the upstream port.
// - Non-zero upper address gives a 64-bit message address.
// - Zero upper address gives a 32-bit address from the lower field only.
// - Writable 16-bit payload forms the message data; upper register half reads zero.
// - Subsystem identification header low byte reads fixed 0xD.
// - Lockable writable card maker low half and card product high half, reset zero.
// - Pointer register-number field selects the dword register for indirect access.
// - Pointer four-bit page field selects the extended page; upper bits read zero.
// - Window accesses read or update the pointed register with the access byte enables.
// - Pointer aimed at the window itself makes window reads zero and writes ignored.
package msc_pkg;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_MSI_CAP   = 12'h0D0;
  localparam logic [11:0] OFS_MSI_LO    = 12'h0D4;
  localparam logic [11:0] OFS_MSI_HI    = 12'h0D8;
  localparam logic [11:0] OFS_MSI_DATA  = 12'h0DC;
  localparam logic [11:0] OFS_SUBS_CAP  = 12'h0F0;
  localparam logic [11:0] OFS_SUBS_VAL  = 12'h0F4;
  localparam logic [11:0] OFS_IND_PTR   = 12'h0F8;
  localparam logic [11:0] OFS_IND_WIN   = 12'h0FC;
  localparam logic [7:0]  MSI_CAP_ID    = 8'h05;
  localparam logic [7:0]  SUBS_CAP_ID   = 8'h0D;
  localparam logic [7:0]  NEXT_CAP_LINK = 8'h00;
  localparam logic [2:0]  MSG_CAPABLE   = 3'h0;
  localparam logic        WIDE_CAPABLE  = 1'b1;
  localparam int          EN_BIT        = 16;
  localparam int          MMC_LSB       = 17;
  localparam int          GRANT_LSB     = 20;
  localparam int          WIDE_BIT      = 23;
  localparam int          NXT_LSB       = 8;
  localparam int          ADDR_LSB      = 2;
  localparam int          REG_LSB       = 2;
  localparam int          REG_W         = 6;
  localparam int          PAGE_LSB      = 8;
  localparam int          PAGE_W        = 4;
  localparam int          PAYLOAD_W     = 16;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  typedef enum logic {MSC_IDLE, MSC_SEND} msc_state_e;
endpackage : msc_pkg

// *** design/msc_cfg_block.sv ***
/*
  Configuration registers for the interrupt-message capability, the subsystem
  identification capability and the indirect configuration access pair.
  Assumes one configuration request per cycle at most and a message sink that
  acknowledges each request.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_cfg_block (
  input  wire logic                      i_clock,
  input  wire logic                      i_nrst,
  input  wire logic                      i_clk_en,
  input  wire logic                      i_cfg_req,
  input  wire logic                      i_cfg_wr,
  input  wire logic [msc_pkg::ADDR_W-1:0] i_cfg_addr,
  input  wire logic [3:0]                i_cfg_be,
  input  wire logic [31:0]               i_cfg_wdata,
  input  wire logic                      i_cfg_lock,
  output var  logic                      o_cfg_ack,
  output var  logic [31:0]               o_cfg_rdata,
  input  wire logic                      i_msi_event,
  input  wire logic                      i_msi_ack,
  output var  logic                      o_msi_req,
  output var  logic [63:0]               o_msi_addr,
  output var  logic                      o_msi_wide,
  output var  logic [31:0]               o_msi_data,
  output var  logic                      o_msi_upstream
);
  import msc_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic                  msi_en;
  logic [2:0]            multi_msg_granted;
  logic [31:ADDR_LSB]    msg_address_low_reg;
  logic [31:0]           upper_msg_address;
  logic [PAYLOAD_W-1:0]  msg_payload;
  logic [15:0]           card_maker_code;
  logic [15:0]           card_product_code;
  logic [REG_W-1:0]      cfg_reg_index;
  logic [PAGE_W-1:0]     cfg_ext_page_index;
  logic                  next_msi_en;
  logic [2:0]            next_multi_msg_granted;
  logic [31:ADDR_LSB]    next_msg_address_low_reg;
  logic [31:0]           next_upper_msg_address;
  logic [PAYLOAD_W-1:0]  next_msg_payload;
  logic [15:0]           next_card_maker_code;
  logic [15:0]           next_card_product_code;
  logic [REG_W-1:0]      next_cfg_reg_index;
  logic [PAGE_W-1:0]     next_cfg_ext_page_index;
  logic                  next_cfg_ack;
  logic [31:0]           next_cfg_rdata;
  logic [11:0]           dw_addr;
  logic [11:0]           ptr_addr;
  logic [11:0]           eff_addr;
  logic                  win_blocked;
  logic [31:0]           cur_val;
  logic [31:0]           merged;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = new_v[8*k +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // ****************************************
  // Register access
  // ****************************************
  always_comb begin
    dw_addr     = {i_cfg_addr[11:2], 2'b00};
    ptr_addr    = {cfg_ext_page_index, cfg_reg_index, 2'b00};
    eff_addr    = (dw_addr == OFS_IND_WIN) ? ptr_addr : dw_addr;
    win_blocked = (dw_addr == OFS_IND_WIN) && (ptr_addr == OFS_IND_WIN);
    case (eff_addr)
      OFS_MSI_CAP:  cur_val = {8'h00, WIDE_CAPABLE, multi_msg_granted, MSG_CAPABLE, msi_en,
                               NEXT_CAP_LINK, MSI_CAP_ID};
      OFS_MSI_LO:   cur_val = {msg_address_low_reg, 2'b00};
      OFS_MSI_HI:   cur_val = upper_msg_address;
      OFS_MSI_DATA: cur_val = {16'h0000, msg_payload};
      OFS_SUBS_CAP: cur_val = {16'h0000, NEXT_CAP_LINK, SUBS_CAP_ID};
      OFS_SUBS_VAL: cur_val = {card_product_code, card_maker_code};
      OFS_IND_PTR:  cur_val = {20'h00000, cfg_ext_page_index, cfg_reg_index, 2'b00};
      default:      cur_val = RST_ZERO;
    endcase
    merged                   = be_merge(cur_val, i_cfg_wdata, i_cfg_be);
    next_msi_en              = msi_en;
    next_multi_msg_granted   = multi_msg_granted;
    next_msg_address_low_reg = msg_address_low_reg;
    next_upper_msg_address   = upper_msg_address;
    next_msg_payload         = msg_payload;
    next_card_maker_code     = card_maker_code;
    next_card_product_code   = card_product_code;
    next_cfg_reg_index       = cfg_reg_index;
    next_cfg_ext_page_index  = cfg_ext_page_index;
    next_cfg_ack             = i_cfg_req;
    next_cfg_rdata           = (i_cfg_req && !i_cfg_wr) ? cur_val : RST_ZERO;
    if (i_cfg_req && i_cfg_wr && !win_blocked) begin
      case (eff_addr)
        OFS_MSI_CAP: begin
          next_msi_en            = merged[EN_BIT];
          next_multi_msg_granted = merged[GRANT_LSB +: 3];
        end
        OFS_MSI_LO:   next_msg_address_low_reg = merged[31:ADDR_LSB];
        OFS_MSI_HI:   next_upper_msg_address   = merged;
        OFS_MSI_DATA: next_msg_payload         = merged[PAYLOAD_W-1:0];
        OFS_SUBS_VAL: begin
          if (!i_cfg_lock) begin
            next_card_maker_code   = merged[15:0];
            next_card_product_code = merged[31:16];
          end
        end
        OFS_IND_PTR: begin
          next_cfg_reg_index      = merged[REG_LSB +: REG_W];
          next_cfg_ext_page_index = merged[PAGE_LSB +: PAGE_W];
        end
        default: next_msi_en = msi_en;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      msi_en              <= 1'b0;
      multi_msg_granted   <= 3'h0;
      msg_address_low_reg <= RST_ZERO[31:ADDR_LSB];
      upper_msg_address   <= RST_ZERO;
      msg_payload         <= RST_ZERO[PAYLOAD_W-1:0];
      card_maker_code     <= RST_ZERO[15:0];
      card_product_code   <= RST_ZERO[15:0];
      cfg_reg_index       <= RST_ZERO[REG_W-1:0];
      cfg_ext_page_index  <= RST_ZERO[PAGE_W-1:0];
      o_cfg_ack           <= 1'b0;
      o_cfg_rdata         <= RST_ZERO;
    end else if (i_clk_en) begin
      msi_en              <= next_msi_en;
      multi_msg_granted   <= next_multi_msg_granted;
      msg_address_low_reg <= next_msg_address_low_reg;
      upper_msg_address   <= next_upper_msg_address;
      msg_payload         <= next_msg_payload;
      card_maker_code     <= next_card_maker_code;
      card_product_code   <= next_card_product_code;
      cfg_reg_index       <= next_cfg_reg_index;
      cfg_ext_page_index  <= next_cfg_ext_page_index;
      o_cfg_ack           <= next_cfg_ack;
      o_cfg_rdata         <= next_cfg_rdata;
    end
  end

  // ****************************************
  // Interrupt message issue
  // ****************************************
  msc_state_e  state;
  msc_state_e  next_state;
  logic        pend;
  logic        next_pend;
  logic        next_msi_req;
  logic [63:0] next_msi_addr;
  logic        next_msi_wide;
  logic [31:0] next_msi_data;
  logic        wide_now;

  always_comb begin
    wide_now      = (upper_msg_address != RST_ZERO);
    next_state    = state;
    next_pend     = pend;
    next_msi_req  = o_msi_req;
    next_msi_addr = o_msi_addr;
    next_msi_wide = o_msi_wide;
    next_msi_data = o_msi_data;
    case (state)
      MSC_IDLE: begin
        if (msi_en && (i_msi_event || pend)) begin
          next_state    = MSC_SEND;
          next_msi_req  = 1'b1;
          next_pend     = pend && i_msi_event;
          next_msi_wide = wide_now;
          next_msi_addr = wide_now ? {upper_msg_address, msg_address_low_reg, 2'b00}
                                   : {32'h0000_0000, msg_address_low_reg, 2'b00};
          next_msi_data = {16'h0000, msg_payload};
        end
      end
      MSC_SEND: begin
        if (i_msi_event && msi_en) begin
          next_pend = 1'b1;
        end
        if (i_msi_ack) begin
          next_state   = MSC_IDLE;
          next_msi_req = 1'b0;
        end
      end
      default: next_state = MSC_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state          <= MSC_IDLE;
      pend           <= 1'b0;
      o_msi_req      <= 1'b0;
      o_msi_addr     <= 64'h0000_0000_0000_0000;
      o_msi_wide     <= 1'b0;
      o_msi_data     <= RST_ZERO;
      o_msi_upstream <= 1'b0;
    end else if (i_clk_en) begin
      state          <= next_state;
      pend           <= next_pend;
      o_msi_req      <= next_msi_req;
      o_msi_addr     <= next_msi_addr;
      o_msi_wide     <= next_msi_wide;
      o_msi_data     <= next_msi_data;
      o_msi_upstream <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  logic rd_go;
  assign rd_go = i_cfg_req && !i_cfg_wr && i_clk_en;

  a_next_link_zero: assert property (rd_go && dw_addr == OFS_MSI_CAP |=> o_cfg_rdata[15:8] == 8'h00)
    else $error("next pointer not zero");
  a_msg_gate: assert property ($rose(o_msi_req) |-> $past(msi_en))
    else $error("message issued while disabled");
  a_count_zero: assert property (rd_go && dw_addr == OFS_MSI_CAP |=> o_cfg_rdata[19:17] == 3'h0)
    else $error("message count not zero");
  a_one_msg_data: assert property ($rose(o_msi_req) |-> o_msi_data == {16'h0000, $past(msg_payload)})
    else $error("payload altered");
  a_wide_cap: assert property (rd_go && dw_addr == OFS_MSI_CAP |=> o_cfg_rdata[23])
    else $error("wide capable bit clear");
  a_low_addr_align: assert property (o_msi_req |-> o_msi_addr[1:0] == 2'b00)
    else $error("message address unaligned");
  a_upstream_fwd: assert property (o_msi_req |-> o_msi_upstream)
    else $error("message not sent upstream");
  a_wide_select: assert property (o_msi_req |-> o_msi_wide == (o_msi_addr[63:32] != 32'h0))
    else $error("width select wrong");
  a_narrow_select: assert property ($rose(o_msi_req) && $past(upper_msg_address) == 32'h0
                                    |-> !o_msi_wide)
    else $error("narrow address not used");
  a_payload_high: assert property (rd_go && dw_addr == OFS_MSI_DATA |=> o_cfg_rdata[31:16] == 16'h0)
    else $error("payload upper half not zero");
  a_subs_cap_id: assert property (rd_go && dw_addr == OFS_SUBS_CAP |=> o_cfg_rdata[7:0] == 8'h0D)
    else $error("identification header wrong");
  a_lock_hold: assert property (i_clk_en && i_cfg_lock |=> $stable(card_maker_code))
    else $error("locked field changed");
  a_window_self: assert property (rd_go && win_blocked |=> o_cfg_rdata == 32'h0)
    else $error("self window read not zero");
  a_ack_timing: assert property (i_cfg_req && i_clk_en |=> o_cfg_ack)
    else $error("access not answered");

  c_wide_msg:   cover property ($rose(o_msi_req) && o_msi_wide);
  c_narrow_msg: cover property ($rose(o_msi_req) && !o_msi_wide);
  c_win_read:   cover property (rd_go && dw_addr == OFS_IND_WIN && !win_blocked);
  c_pend_msg:   cover property (pend && state == MSC_SEND);
endmodule : msc_cfg_block
`default_nettype wire

// *** verif/msc_msg_sink.sv ***
/*
  Message sink standing for the root complex that takes interrupt memory writes.
  Assumes the block holds its request until the acknowledge is sampled high.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_msg_sink (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_msi_req,
  input  wire logic [3:0] i_delay,
  output var  logic       o_msi_ack
);
  // ****************************************
  // Acknowledge after a chosen wait
  // ****************************************
  logic [3:0] wait_cnt;
  // A one-cycle acknowledge is raised once the request has waited i_delay cycles.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_cnt  <= 4'h0;
      o_msi_ack <= 1'b0;
    end else begin
      o_msi_ack <= i_msi_req && !o_msi_ack && (wait_cnt == i_delay);
      wait_cnt  <= (i_msi_req && !o_msi_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : msc_msg_sink
`default_nettype wire

// *** verif/msc_cfg_block_tb.sv ***
/*
  Self-checking testbench for the interrupt-message and configuration block.
  Assumes the message sink model and the block package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module msc_cfg_block_tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clock = 0, nrst = 0, clk_en = 1, cfg_req = 0, cfg_wr = 0, cfg_lock = 0, msi_event = 0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0]  cfg_be = 4'h0, delay = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, msi_data, q;
  logic        cfg_ack, msi_ack, msi_req, msi_wide, msi_up;
  logic [63:0] msi_addr;
  int          num_errors = 0, compares = 0;
  msc_cfg_block u_msc_cfg_block (.i_clock(clock), .i_nrst(nrst), .i_clk_en(clk_en), .i_cfg_req(cfg_req),
    .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .i_cfg_lock(cfg_lock),
    .o_cfg_ack(cfg_ack), .o_cfg_rdata(cfg_rdata), .i_msi_event(msi_event), .i_msi_ack(msi_ack),
    .o_msi_req(msi_req), .o_msi_addr(msi_addr), .o_msi_wide(msi_wide), .o_msi_data(msi_data),
    .o_msi_upstream(msi_up));
  msc_msg_sink u_msc_msg_sink (.i_clock(clock), .i_nrst(nrst), .i_msi_req(msi_req), .i_delay(delay),
    .o_msi_ack(msi_ack));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfg_req   <= 1'b1;
    cfg_wr    <= wr;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_req <= 1'b0;
    #1;
    chk(cfg_ack, 1'b1);
    q = cfg_rdata;
  endtask : cfg
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'hF, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg(1'b1, a, be, d);
    chk(q, 32'h0);
  endtask : wr
  task automatic pulse;
    @(posedge clock);
    msi_event <= 1'b1;
    @(posedge clock);
    msi_event <= 1'b0;
  endtask : pulse
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(12'h0D0, 32'h0080_0005);
    rd(12'h0D4, 32'h0);
    rd(12'h0D8, 32'h0);
    rd(12'h0DC, 32'h0);
    rd(12'h0F0, 32'h0000_000D);
    rd(12'h0F4, 32'h0);
    rd(12'h0F8, 32'h0);
    rd(12'h0E0, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    wr(12'h0D0, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0D0, 32'h00F1_0005);
    wr(12'h0D4, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0D4, 32'hFFFF_FFFC);
    wr(12'h0DC, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0DC, 32'h0000_FFFF);
    wr(12'h0F0, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0F0, 32'h0000_000D);
    wr(12'h0F8, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0F8, 32'h0000_0FFC);
    wr(12'h0D8, 4'h2, 32'h1234_5678);
    rd(12'h0D8, 32'h0000_5600);
    $display("test fields done");
  endtask : t_fields
  task automatic t_lock;
    cfg_lock <= 1'b1;
    wr(12'h0F4, 4'hF, 32'hAAAA_5555);
    rd(12'h0F4, 32'h0);
    cfg_lock <= 1'b0;
    wr(12'h0F4, 4'hF, 32'hAAAA_5555);
    rd(12'h0F4, 32'hAAAA_5555);
    $display("test lock done");
  endtask : t_lock
  task automatic t_window;
    wr(12'h0F8, 4'hF, 32'h0000_00DC);
    wr(12'h0FC, 4'h1, 32'hFFFF_FFA5);
    rd(12'h0DC, 32'h0000_FFA5);
    rd(12'h0FC, 32'h0000_FFA5);
    wr(12'h0F8, 4'hF, 32'h0000_01DC);
    rd(12'h0FC, 32'h0);
    wr(12'h0F8, 4'hF, 32'h0000_00FC);
    wr(12'h0FC, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0FC, 32'h0);
    rd(12'h0F8, 32'h0000_00FC);
    $display("test window done");
  endtask : t_window
  task automatic msg(input logic [63:0] a, input logic wide);
    int i;
    pulse();
    for (i = 0; i < 20 && msi_req !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk(msi_req, 1'b1);
    chk(msi_addr, a);
    chk(msi_wide, wide);
    chk(msi_data, 32'h0000_1234);
    chk(msi_up, 1'b1);
    for (i = 0; i < 40 && msi_req !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    chk(msi_req, 1'b0);
  endtask : msg
  task automatic t_msg;
    int i;
    wr(12'h0D0, 4'hF, 32'h0);
    wr(12'h0D4, 4'hF, 32'hFEE0_0010);
    wr(12'h0D8, 4'hF, 32'h0);
    wr(12'h0DC, 4'hF, 32'h0000_1234);
    pulse();
    for (i = 0; i < 10; i++) begin
      @(posedge clock);
      #1;
      chk(msi_req, 1'b0);
    end
    wr(12'h0D0, 4'hF, 32'h0071_0000);
    delay <= 4'h3;
    msg(64'h0000_0000_FEE0_0010, 1'b0);
    wr(12'h0D8, 4'hF, 32'h0000_0001);
    delay <= 4'h0;
    msg(64'h0000_0001_FEE0_0010, 1'b1);
    $display("test messages done");
  endtask : t_msg
  task automatic t_pend;
    int   i;
    int   n;
    logic prev;
    n = 0;
    prev = 1'b0;
    delay <= 4'h4;
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      msi_event <= (i == 0 || i == 2 || i == 4 || i == 7);
      #1;
      if (msi_req === 1'b1 && prev === 1'b0) begin
        n++;
      end
      prev = msi_req;
    end
    chk(n, 3);
    chk(msi_req, 1'b0);
    $display("test pending done");
  endtask : t_pend
  task automatic t_freeze;
    @(posedge clock);
    clk_en    <= 1'b0;
    cfg_req   <= 1'b1;
    cfg_wr    <= 1'b1;
    cfg_addr  <= 12'h0DC;
    cfg_be    <= 4'hF;
    cfg_wdata <= 32'h0000_BEEF;
    repeat (3) @(posedge clock);
    cfg_req <= 1'b0;
    #1;
    chk(cfg_ack, 1'b0);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(12'h0DC, 32'h0000_1234);
    $display("test freeze done");
  endtask : t_freeze
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_lock();
    t_window();
    t_msg();
    t_pend();
    t_freeze();
    end_sim();
  end
  initial begin
    #(25 * 4000);
    num_errors++;
    end_sim();
  end
endmodule : msc_cfg_block_tb
`default_nettype wire
